// ==== cpu_exec_pkg.sv ====
/*
  constants, opcodes, register map and helpers for the 4-bit
  instruction execute core.
  assumes a 10-bit program word and a 4-bit data memory.
*/
package cpu_exec_pkg;
  // datapath widths
  localparam int WORD_W  = 10;
  localparam int PC_W    = 12;
  localparam int LOW_W   = 7;
  localparam int NIB_W   = 4;
  localparam int DP_W    = 8;
  localparam int SP_W    = 3;
  localparam int D_W     = 3;
  localparam int BYTE_W  = 8;
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  localparam int STACK_DEPTH = 8;
  localparam logic [SP_W-1:0]  SP_ONE   = 3'h1;
  localparam logic [LOW_W-1:0] LOW_ONE  = 7'h01;
  localparam logic [4:0]       PAGE_CALL = 5'h02;
  localparam logic [PC_W-1:0]  RESET_PC = 12'h000;
  localparam logic [PC_W-1:0]  IRQ_VECTOR = 12'h008;
  // opcodes and their compare masks
  localparam logic [9:0] MASK_ALL  = 10'h3FF;
  localparam logic [9:0] MASK_NIB  = 10'h3F0;
  localparam logic [9:0] MASK_PAGE = 10'h3E0;
  localparam logic [9:0] MASK_BIT  = 10'h3FC;
  localparam logic [9:0] MASK_ADDR = 10'h380;
  localparam logic [9:0] OP_LA    = 10'h070;
  localparam logic [9:0] OP_ROM_TABLE_READ  = 10'h080;
  localparam logic [9:0] OP_AM    = 10'h00A;
  localparam logic [9:0] OP_AMC   = 10'h00B;
  localparam logic [9:0] OP_ADDI  = 10'h060;
  localparam logic [9:0] OP_AND   = 10'h018;
  localparam logic [9:0] OP_OR    = 10'h019;
  localparam logic [9:0] OP_SC    = 10'h007;
  localparam logic [9:0] OP_RC    = 10'h006;
  localparam logic [9:0] OP_SZC   = 10'h02F;
  localparam logic [9:0] OP_CMA   = 10'h01C;
  localparam logic [9:0] OP_RAR   = 10'h01D;
  localparam logic [9:0] OP_SB    = 10'h05C;
  localparam logic [9:0] OP_RB    = 10'h04C;
  localparam logic [9:0] OP_SZB   = 10'h020;
  localparam logic [9:0] OP_COMPARE_ACC_MEMORY  = 10'h026;
  localparam logic [9:0] OP_SEA   = 10'h025;
  localparam logic [9:0] OP_B     = 10'h180;
  localparam logic [9:0] OP_BL    = 10'h0E0;
  localparam logic [9:0] OP_BLA   = 10'h010;
  localparam logic [9:0] OP_BM    = 10'h100;
  localparam logic [9:0] OP_BML   = 10'h0C0;
  localparam logic [9:0] OP_FAR_CALL_INDIRECT  = 10'h030;
  localparam logic [9:0] OP_RTI   = 10'h046;
  localparam logic [9:0] OP_RT    = 10'h044;
  localparam logic [9:0] OP_RTS   = 10'h045;
  localparam logic [9:0] OP_DI    = 10'h004;
  localparam logic [9:0] OP_EI    = 10'h005;
  localparam logic [9:0] OP_EXT_FLAG_TEST  = 10'h038;
  localparam logic [9:0] OP_INT_PIN_LEVEL_TEST = 10'h03A;
  localparam logic [9:0] OP_PRESCALER_WRITE = 10'h235;
  localparam logic [9:0] OP_T1AB  = 10'h230;
  // register map and config fields
  localparam logic [ADDR_W-1:0] REG_CONFIG    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ACCB      = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PRESCALER = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_TIMER1    = 8'h10;
  localparam int CFG_HIGH_BITS_TABLE_FLAG = 0;
  localparam int CFG_V10  = 1;
  localparam int CFG_I12  = 2;
  localparam int CFG_D_LSB = 4;

  // sequencer states
  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_EXEC  = 3'b001,
    ST_WORD2 = 3'b010,
    ST_TABLE = 3'b011,
    ST_IDLE2 = 3'b100
  } state_type;

  // masked opcode match
  function automatic logic op_is(input logic [9:0] w,
                                 input logic [9:0] code,
                                 input logic [9:0] mask);
    op_is = ((w & mask) == code);
  endfunction : op_is

  // 4-bit add with carry in, carry out on top
  function automatic logic [4:0] add4(input logic [3:0] x,
                                      input logic [3:0] y,
                                      input logic       c);
    add4 = {1'b0, x} + {1'b0, y} + {4'h0, c};
  endfunction : add4

  // one-hot nibble mask for bit j
  function automatic logic [3:0] bit_mask(input logic [1:0] j);
    bit_mask = 4'h1 << j;
  endfunction : bit_mask

  // instructions that carry a second word
  function automatic logic two_word(input logic [9:0] w);
    two_word = op_is(w, OP_BL, MASK_PAGE) || op_is(w, OP_BML, MASK_PAGE)
            || op_is(w, OP_BLA, MASK_ALL) || op_is(w, OP_FAR_CALL_INDIRECT, MASK_ALL)
            || op_is(w, OP_SEA, MASK_ALL);
  endfunction : two_word
endpackage : cpu_exec_pkg

// ==== cpu_instruction_execute.sv ====
/*
  execute core for a subset of a 4-bit instruction set, with a
  program rom port, a data memory port and a small register port.
  assumes a synchronous rom and ram that answer one cycle after the
  address, and an interrupt requester on the same clock.
*/
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - consecutive immediate loads: only first executes
// - table read loads B and A from rom
// - high-bits flag also loads D, clears D2
// - table read borrows one stack level
// - plain add keeps carry unchanged
// - add with carry updates carry out
// - add immediate skips when no overflow
// - and/or combine accumulator with memory
// - set/clear carry; skip when carry clear
// - complement inverts the accumulator
// - rotate right through carry
// - set, clear, test memory bit j
// - compare skips on equality
// - in-page branch keeps page, one cycle
// - far branch loads page and address
// - page-two call pushes and jumps
// - far calls push then jump
// - interrupt return restores saved state
// - return takes two cycles; variant skips
// - ext flag test skips and clears flag
// - pin level test honours polarity bit
// - prescaler write loads reload and counter
module cpu_instruction_execute
  import cpu_exec_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  output logic [PC_W-1:0]        rom_addr,
  input  wire logic [WORD_W-1:0] rom_data,
  output logic [DP_W-1:0]        ram_addr,
  input  wire logic [NIB_W-1:0]  ram_rdata,
  output logic [NIB_W-1:0]       ram_wdata,
  output logic                   ram_we,
  input  wire logic [DP_W-1:0]   dp_in,
  output logic [DP_W-1:0]        dp_restore_val,
  output logic                   dp_restore,
  input  wire logic              irq_req,
  output logic                   irq_ack,
  input  wire logic              ext0_event,
  input  wire logic              int_pin,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata
);
  state_type         state_reg;                 // sequencer state
  logic [PC_W-1:0]   pc_reg;                    // page and low part
  logic [PC_W-1:0]   stack_reg [STACK_DEPTH];   // return stack
  logic [SP_W-1:0]   sp_reg;                    // stack pointer
  logic [NIB_W-1:0]  acc_reg, b_reg;            // accumulator, B
  logic [D_W-1:0]    d_reg;                     // register D
  logic              cy_reg, skip_reg, la_run_reg, interrupt_master_enable_reg;
  logic [WORD_W-1:0] ir1_reg;                   // first word held
  logic [NIB_W-1:0]  sv_acc_reg, sv_b_reg;      // interrupt shadows
  logic              sv_cy_reg, sv_skip_reg, sv_la_reg;
  logic [DP_W-1:0]   sv_dp_reg;
  logic [BYTE_W-1:0] pre_reload_reg, pre_count_reg;
  logic [BYTE_W-1:0] t1_reload_reg, t1_count_reg;
  logic              high_bits_table_flag_reg, v10_reg, i12_reg; // config bits
  logic              ext0_reg;                  // ext0 request flag
  logic              pin_meta_reg, pin_sync_reg;
  logic [PC_W-1:0]   rom_addr_reg;
  logic [DP_W-1:0]   ram_addr_reg, dp_out_reg;
  logic [NIB_W-1:0]  ram_wdata_reg;
  logic              ram_we_reg, irq_ack_reg, dp_restore_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic [SP_W-1:0]   sp_up;                     // next push slot
  logic [9:0]        w;                         // word on rom bus
  logic              exec_live;                 // instruction acts
  logic              ext0_clr;                  // flag test clears
  logic [4:0]        amc_sum, addi_sum;         // adder outputs

  assign w         = rom_data;
  assign sp_up     = sp_reg + SP_ONE;
  assign amc_sum   = add4(acc_reg, ram_rdata, cy_reg);
  assign addi_sum  = add4(acc_reg, w[3:0], 1'b0);
  assign exec_live = (state_reg == ST_EXEC) && !skip_reg
                     && !(op_is(w, OP_LA, MASK_NIB) && la_run_reg);
  assign ext0_clr  = exec_live && op_is(w, OP_EXT_FLAG_TEST, MASK_ALL)
                     && !v10_reg;

  assign rom_addr       = rom_addr_reg;
  assign ram_addr       = ram_addr_reg;
  assign ram_wdata      = ram_wdata_reg;
  assign ram_we         = ram_we_reg;
  assign dp_restore_val = dp_out_reg;
  assign dp_restore     = dp_restore_reg;
  assign irq_ack        = irq_ack_reg;
  assign reg_rdata      = rd_data_reg;

  // next address in the same page, low part wraps
  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] p);
    pc_inc = {p[PC_W-1:LOW_W], p[LOW_W-1:0] + LOW_ONE};
  endfunction : pc_inc

  // two-stage synchroniser for the interrupt pin
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= int_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ext0 request flag: event set wins over the test's clear
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ext0_reg <= 1'b0;
    else if (ext0_event)
      ext0_reg <= 1'b1;
    else if (ext0_clr)
      ext0_reg <= 1'b0;
  end

  // register port: config writes and one-cycle-late reads
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      high_bits_table_flag_reg    <= 1'b0;
      v10_reg     <= 1'b0;
      i12_reg     <= 1'b0;
      rd_data_reg <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == REG_CONFIG)
      begin
        high_bits_table_flag_reg <= reg_wdata[CFG_HIGH_BITS_TABLE_FLAG];
        v10_reg  <= reg_wdata[CFG_V10];
        i12_reg  <= reg_wdata[CFG_I12];
      end
      rd_data_reg <= '0;  // unmapped or idle reads as zero
      if (reg_rd)
      begin
        unique case (reg_addr)
          REG_CONFIG:    rd_data_reg <= DATA_W'({d_reg, 1'b0, i12_reg,
                                         v10_reg, high_bits_table_flag_reg});
          REG_ACCB:      rd_data_reg <= DATA_W'({b_reg, acc_reg});
          REG_STATUS:    rd_data_reg <= DATA_W'({d_reg, sp_reg,
                           la_run_reg, skip_reg, ext0_reg, interrupt_master_enable_reg,
                           cy_reg});
          REG_PRESCALER: rd_data_reg <= DATA_W'({pre_reload_reg,
                                                 pre_count_reg});
          REG_TIMER1:    rd_data_reg <= DATA_W'({t1_reload_reg,
                                                 t1_count_reg});
          default:       rd_data_reg <= '0;
        endcase
      end
    end
  end

  // sequencer and datapath
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_FETCH;
      pc_reg <= RESET_PC;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack_reg[i] <= RESET_PC;
      sp_reg <= '0; acc_reg <= '0; b_reg <= '0; d_reg <= '0;
      cy_reg <= 1'b0; skip_reg <= 1'b0; la_run_reg <= 1'b0;
      interrupt_master_enable_reg <= 1'b0; ir1_reg <= '0;
      sv_acc_reg <= '0; sv_b_reg <= '0; sv_dp_reg <= '0;
      sv_cy_reg <= 1'b0; sv_skip_reg <= 1'b0; sv_la_reg <= 1'b0;
      pre_reload_reg <= '0; pre_count_reg <= '0;
      t1_reload_reg <= '0; t1_count_reg <= '0;
      rom_addr_reg <= '0; ram_addr_reg <= '0; ram_wdata_reg <= '0;
      ram_we_reg <= 1'b0; irq_ack_reg <= 1'b0;
      dp_restore_reg <= 1'b0; dp_out_reg <= '0;
    end
    else
    begin
      ram_we_reg     <= 1'b0;
      irq_ack_reg    <= 1'b0;
      dp_restore_reg <= 1'b0;
      // software may load D through the config register
      if (reg_wr && reg_addr == REG_CONFIG)
        d_reg <= reg_wdata[CFG_D_LSB +: D_W];
      unique case (state_reg)
        ST_FETCH:
        begin
          if (irq_req && interrupt_master_enable_reg)
          begin
            // take the interrupt: save state, push, vector
            sp_reg <= sp_up;
            stack_reg[sp_up] <= pc_reg;
            sv_acc_reg <= acc_reg; sv_b_reg <= b_reg;
            sv_cy_reg <= cy_reg; sv_skip_reg <= skip_reg;
            sv_la_reg <= la_run_reg; sv_dp_reg <= dp_in;
            skip_reg <= 1'b0; la_run_reg <= 1'b0;
            interrupt_master_enable_reg <= 1'b0; irq_ack_reg <= 1'b1;
            pc_reg <= IRQ_VECTOR;
          end
          else
          begin
            rom_addr_reg <= pc_reg;
            ram_addr_reg <= dp_in;
            pc_reg <= pc_inc(pc_reg);
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC:
        begin
          la_run_reg <= op_is(w, OP_LA, MASK_NIB);
          state_reg <= ST_FETCH;
          if (!exec_live)
          begin
            // skipped: only sequencing, second word stepped over
            skip_reg <= 1'b0;
            if (two_word(w))
            begin
              pc_reg <= pc_inc(pc_reg);
              state_reg <= ST_IDLE2;
            end
          end
          else if (two_word(w))
          begin
            // fetch the second word
            ir1_reg <= w;
            rom_addr_reg <= pc_reg;
            pc_reg <= pc_inc(pc_reg);
            state_reg <= ST_WORD2;
          end
          else if (op_is(w, OP_LA, MASK_NIB))
            acc_reg <= w[3:0];
          else if (op_is(w, OP_ROM_TABLE_READ, MASK_PAGE))
          begin
            sp_reg <= sp_up;
            stack_reg[sp_up] <= pc_reg;
            rom_addr_reg <= {w[4:0], d_reg, acc_reg};
            state_reg <= ST_TABLE;
          end
          else if (op_is(w, OP_AM, MASK_ALL))
            acc_reg <= amc_sum[3:0] - {3'h0, cy_reg};
          else if (op_is(w, OP_AMC, MASK_ALL))
            {cy_reg, acc_reg} <= amc_sum;
          else if (op_is(w, OP_ADDI, MASK_NIB))
          begin
            acc_reg <= addi_sum[3:0];
            skip_reg <= !addi_sum[4];
          end
          else if (op_is(w, OP_AND, MASK_ALL))
            acc_reg <= acc_reg & ram_rdata;
          else if (op_is(w, OP_OR, MASK_ALL))
            acc_reg <= acc_reg | ram_rdata;
          else if (op_is(w, OP_SC, MASK_ALL))
            cy_reg <= 1'b1;
          else if (op_is(w, OP_RC, MASK_ALL))
            cy_reg <= 1'b0;
          else if (op_is(w, OP_SZC, MASK_ALL))
            skip_reg <= !cy_reg;
          else if (op_is(w, OP_CMA, MASK_ALL))
            acc_reg <= ~acc_reg;
          else if (op_is(w, OP_RAR, MASK_ALL))
          begin
            acc_reg <= {cy_reg, acc_reg[3:1]};
            cy_reg <= acc_reg[0];
          end
          else if (op_is(w, OP_SB, MASK_BIT) || op_is(w, OP_RB, MASK_BIT))
          begin
            // read-modify-write of the addressed nibble
            ram_we_reg <= 1'b1;
            ram_wdata_reg <= op_is(w, OP_SB, MASK_BIT)
                             ? (ram_rdata | bit_mask(w[1:0]))
                             : (ram_rdata & ~bit_mask(w[1:0]));
          end
          else if (op_is(w, OP_SZB, MASK_BIT))
            skip_reg <= !(|(ram_rdata & bit_mask(w[1:0])));
          else if (op_is(w, OP_COMPARE_ACC_MEMORY, MASK_ALL))
            skip_reg <= (acc_reg == ram_rdata);
          else if (op_is(w, OP_B, MASK_ADDR))
            pc_reg <= {pc_reg[PC_W-1:LOW_W], w[6:0]};
          else if (op_is(w, OP_BM, MASK_ADDR))
          begin
            sp_reg <= sp_up;
            stack_reg[sp_up] <= pc_reg;
            pc_reg <= {PAGE_CALL, w[6:0]};
          end
          else if (op_is(w, OP_RTI, MASK_ALL))
          begin
            pc_reg <= stack_reg[sp_reg];
            sp_reg <= sp_reg - SP_ONE;
            acc_reg <= sv_acc_reg; b_reg <= sv_b_reg;
            cy_reg <= sv_cy_reg; skip_reg <= sv_skip_reg;
            la_run_reg <= sv_la_reg;
            dp_out_reg <= sv_dp_reg; dp_restore_reg <= 1'b1;
          end
          else if (op_is(w, OP_RT, MASK_ALL) || op_is(w, OP_RTS, MASK_ALL))
          begin
            pc_reg <= stack_reg[sp_reg];
            sp_reg <= sp_reg - SP_ONE;
            skip_reg <= op_is(w, OP_RTS, MASK_ALL);
            state_reg <= ST_IDLE2;
          end
          else if (op_is(w, OP_DI, MASK_ALL))
            interrupt_master_enable_reg <= 1'b0;
          else if (op_is(w, OP_EI, MASK_ALL))
            interrupt_master_enable_reg <= 1'b1;
          else if (op_is(w, OP_EXT_FLAG_TEST, MASK_ALL))
            skip_reg <= !v10_reg && ext0_reg;
          else if (op_is(w, OP_INT_PIN_LEVEL_TEST, MASK_ALL))
            skip_reg <= (pin_sync_reg == i12_reg);
          else if (op_is(w, OP_PRESCALER_WRITE, MASK_ALL))
          begin
            pre_reload_reg <= {b_reg, acc_reg};
            pre_count_reg <= {b_reg, acc_reg};
          end
          else if (op_is(w, OP_T1AB, MASK_ALL))
          begin
            t1_reload_reg <= {b_reg, acc_reg};
            t1_count_reg <= {b_reg, acc_reg};
          end
        end
        ST_WORD2:
        begin
          // second word on the rom bus
          state_reg <= ST_FETCH;
          if (op_is(ir1_reg, OP_SEA, MASK_ALL))
            skip_reg <= (acc_reg == w[3:0]);
          else
          begin
            if (op_is(ir1_reg, OP_BML, MASK_PAGE)
                || op_is(ir1_reg, OP_FAR_CALL_INDIRECT, MASK_ALL))
            begin
              sp_reg <= sp_up;
              stack_reg[sp_up] <= pc_reg;
            end
            if (op_is(ir1_reg, OP_BLA, MASK_ALL)
                || op_is(ir1_reg, OP_FAR_CALL_INDIRECT, MASK_ALL))
              pc_reg <= {w[6], w[3:0], d_reg, acc_reg};
            else
              pc_reg <= {ir1_reg[4:0], w[6:0]};
          end
        end
        ST_TABLE:
        begin
          // table word arrives; give the stack level back
          b_reg <= w[7:4];
          acc_reg <= w[3:0];
          if (high_bits_table_flag_reg)
            d_reg <= {1'b0, w[9:8]};
          pc_reg <= stack_reg[sp_reg];
          sp_reg <= sp_reg - SP_ONE;
          state_reg <= ST_FETCH;
        end
        ST_IDLE2:
          state_reg <= ST_FETCH;  // filler cycle
        default:
          state_reg <= ST_FETCH;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_la_suppressed: assert property (
    (state_reg == ST_EXEC) && !skip_reg && la_run_reg
    && op_is(w, OP_LA, MASK_NIB) |=> $stable(acc_reg))
    else $error("repeated immediate load changed acc");
  a_table_stack: assert property (
    exec_live && op_is(w, OP_ROM_TABLE_READ, MASK_PAGE)
    |=> (sp_reg == $past(sp_up)) ##1 (sp_reg == $past(sp_reg, 2)))
    else $error("table read stack level not balanced");
  a_add_keep_cy: assert property (
    exec_live && op_is(w, OP_AM, MASK_ALL) |=> $stable(cy_reg))
    else $error("plain add touched carry");
  a_amc_result: assert property (
    exec_live && op_is(w, OP_AMC, MASK_ALL)
    |=> {cy_reg, acc_reg} == $past(amc_sum))
    else $error("add with carry wrong");
  a_cma_invert: assert property (
    exec_live && op_is(w, OP_CMA, MASK_ALL)
    |=> acc_reg == ~$past(acc_reg))
    else $error("complement wrong");
  a_branch_page: assert property (
    exec_live && op_is(w, OP_B, MASK_ADDR)
    |=> pc_reg[PC_W-1:LOW_W] == $past(pc_reg[PC_W-1:LOW_W])
        && state_reg == ST_FETCH)
    else $error("in-page branch left its page");
  a_call_page2: assert property (
    exec_live && op_is(w, OP_BM, MASK_ADDR)
    |=> pc_reg[PC_W-1:LOW_W] == PAGE_CALL && sp_reg == $past(sp_up))
    else $error("page two call wrong");
  a_return_two: assert property (
    exec_live && op_is(w, OP_RT, MASK_ALL)
    |=> state_reg == ST_IDLE2 ##1 state_reg == ST_FETCH)
    else $error("return not two cycles");
  a_prescaler_load: assert property (
    exec_live && op_is(w, OP_PRESCALER_WRITE, MASK_ALL)
    |=> pre_count_reg == pre_reload_reg
        && pre_reload_reg == {$past(b_reg), $past(acc_reg)})
    else $error("prescaler write wrong");
  a_skip_inert: assert property (
    (state_reg == ST_EXEC) && skip_reg
    |=> $stable(acc_reg) && $stable(cy_reg) && !ram_we_reg)
    else $error("skipped instruction had effect");

  c_table_read: cover property (exec_live && op_is(w, OP_ROM_TABLE_READ, MASK_PAGE));
  c_irq_return: cover property (irq_ack_reg ##[1:50] dp_restore_reg);
  c_far_call: cover property (state_reg == ST_WORD2
                              && op_is(ir1_reg, OP_BML, MASK_PAGE));
endmodule : cpu_instruction_execute

// ==== cpu_exec_mem.sv ====
/* program rom and data memory model facing the execute core.
   assumes the bench preloads both arrays by hierarchical writes. */
`timescale 1ns/10ps
module cpu_exec_mem
  import cpu_exec_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic [PC_W-1:0]   rom_addr,
  output logic [WORD_W-1:0]      rom_data,
  input  wire logic [DP_W-1:0]   ram_addr,
  output logic [NIB_W-1:0]       ram_rdata,
  input  wire logic [NIB_W-1:0]  ram_wdata,
  input  wire logic              ram_we
);
  logic [WORD_W-1:0] rom_mem [4096]; // program words
  logic [NIB_W-1:0]  ram_mem [256];  // data nibbles
  // reads follow the registered address, so data stand the cycle after
  assign rom_data  = rom_mem[rom_addr];
  assign ram_rdata = ram_mem[ram_addr];
  // write pulse stores the nibble
  always @(posedge mclk)
  begin
    if (ram_we)
      ram_mem[ram_addr] <= ram_wdata;
  end
endmodule : cpu_exec_mem

// ==== test_cpu_instruction_execute.sv ====
/* self-checking bench: short random programs, results read back.
   assumes the memory model answers one cycle after the address. */
`timescale 1ns/10ps
module test_cpu_instruction_execute;
  import cpu_exec_pkg::*;
  logic              mclk = 0, sys_rst = 1, ev = 0, xev, int_pin = 0;
  logic              ram_we, reg_wr = 0, reg_rd = 0, irq = 0;
  logic [PC_W-1:0]   rom_addr;
  logic [WORD_W-1:0] rom_data;
  logic [DP_W-1:0]   ram_addr, dpr, dp_in = 0;
  logic [NIB_W-1:0]  ram_rdata, ram_wdata;
  logic [ADDR_W-1:0] reg_addr = 0;
  logic [DATA_W-1:0] reg_wdata = 0, reg_rdata, accb, stat, psc, cfg;
  logic [9:0]        n, m, k, j, a, p, w, s, ea, ecy, q[$];
  int                err_total = 0, compares = 0, cyc = 0;
  int                seed = 32'h12106EA4;
  cpu_instruction_execute dut (.mclk, .sys_rst, .rom_addr, .rom_data,
    .ram_addr, .ram_rdata, .ram_wdata, .ram_we, .dp_in,
    .dp_restore_val(dpr), .dp_restore(), .irq_req(irq), .irq_ack(),
    .ext0_event(ev), .int_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  cpu_exec_mem mem (.mclk, .rom_addr, .rom_data, .ram_addr, .ram_rdata,
    .ram_wdata, .ram_we);
  // clock and hang guard
  initial
    forever #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
      end_of_test(1);
  end
  function automatic logic [9:0] rnd(input int lim);
    rnd = 10'($unsigned($random(seed)) % lim);
  endfunction : rnd
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one read strobe, data taken in the following cycle
  task rd(input logic [7:0] ad, output logic [31:0] v);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
    @(posedge mclk);
  endtask : rd
  // reset, load program, configure, let it settle in its loop
  task run;
    sys_rst <= 1'b1;
    @(posedge mclk);
    foreach (q[i])
      mem.rom_mem[i] = q[i];
    mem.rom_mem[q.size()] = OP_B | 10'(q.size());
    mem.ram_mem[dp_in] = m[3:0];
    repeat (19) @(posedge mclk);
    sys_rst   <= 1'b0;
    reg_addr  <= REG_CONFIG;
    reg_wdata <= cfg;
    reg_wr    <= 1'b1;
    ev        <= xev;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    ev        <= 1'b0;
    repeat (40) @(posedge mclk);
    rd(REG_ACCB, accb);
    rd(REG_STATUS, stat);
    rd(REG_PRESCALER, psc);
    chk(accb[3:0], ea[3:0]);
    chk(stat[0], ecy[0]);
  endtask : run
  task end_of_test(input int tmo);
    err_total += tmo;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    for (int it = 0; it < 4; it++)
      for (int sc = 0; sc < 14; sc++)
      begin
        n = rnd(16);
        m = rnd(16);
        k = rnd(16);
        j = rnd(4);
        a = rnd(126);
        p = rnd(14) * 2 + 4;
        w = rnd(1024);
        if (j[1])
          m = n;
        if (sc == 10 || sc == 11)
          a = {a[5:4], n[3:0]};  // indirect target then equals a
        s = n + m;
        xev = k[3];
        cfg = 32'({a[6:4], 1'b0, k[2:0]});
        dp_in <= 8'(rnd(256));
        int_pin <= j[0];
        irq <= sc == 13;
        mem.rom_mem[{5'h02, a[6:0]}] = k[0] ? OP_RTS : OP_RT;
        mem.rom_mem[{p[4:0] | 5'h01, a[6:0]}] = sc == 11 ? OP_CMA : OP_RTS;
        mem.rom_mem[{p[4:0] | 5'h01, a[6:0] + 7'h01}] = OP_B | (a + 1);
        mem.rom_mem[{p[4:0], a[6:4], n[3:0]}] = w;
        mem.rom_mem[IRQ_VECTOR] = OP_RC;
        mem.rom_mem[IRQ_VECTOR + 1] = OP_CMA;
        mem.rom_mem[IRQ_VECTOR + 2] = OP_RTI;
        case (sc)
          0: q = '{OP_LA|n, OP_LA|k, OP_RC, OP_AMC, OP_SZC, OP_CMA};
          1: q = '{OP_LA|n, OP_SC, OP_AM, OP_SZC, OP_CMA};
          2: q = '{OP_LA|n, OP_CMA, OP_SC, OP_RAR};
          3: q = '{OP_LA|n, k[0] ? OP_OR : OP_AND};
          4: q = '{OP_LA|n, OP_COMPARE_ACC_MEMORY, OP_CMA};
          5: q = '{OP_LA|n, OP_SEA, 10'h070|m, OP_CMA};
          6: q = '{OP_LA|n, OP_ADDI|k, OP_CMA};
          7: q = '{OP_LA|n, OP_ROM_TABLE_READ|p, OP_PRESCALER_WRITE};
          8: q = '{OP_LA|n, (k[0] ? OP_SB : OP_RB)|j, OP_SZB|j, OP_CMA};
          9: q = '{OP_LA|n, OP_BM|a, OP_CMA};
          10: q = '{OP_LA|n, k[1] ? OP_FAR_CALL_INDIRECT : OP_BML|p|10'h1,
                k[1] ? 10'h200|{p[4], 2'b00, p[3:1], 1'b1} : 10'h200|a,
                OP_CMA};
          11: q = '{OP_LA|n, k[0] ? OP_BLA : OP_BL|p|10'h1,
                k[0] ? 10'h200|{p[4], 2'b00, p[3:1], 1'b1} : 10'h200|a};
          13: q = '{OP_LA|n, OP_SC, OP_EI, OP_CMA};
          default: q = '{OP_LA|n, OP_INT_PIN_LEVEL_TEST, OP_CMA, OP_EXT_FLAG_TEST, OP_CMA};
        endcase
        case (sc)
          0: ea = s[4] ? ~s : s;
          1: ea = ~s;
          2: ea = 10'h8 | ~n >> 1;
          3: ea = k[0] ? n | m : n & m;
          4, 5: ea = n == m ? n : ~n;
          6: ea = n + k > 15 ? ~(n + k) : n + k;
          7: ea = w;
          8: ea = k[0] ? ~n : n;
          9: ea = k[0] ? n : ~n;
          10: ea = n;
          11, 13: ea = ~n;
          default: ea = (j[0] == k[2]) == (k[3] & ~k[1]) ? n : ~n;
        endcase
        ecy = sc == 0 ? s >> 4 : (sc == 1 || sc == 13) ? 10'h1
            : sc == 2 ? ~n : 10'h0;
        run();
        if (sc == 7)
          chk({stat[10:5], psc[15:0]}, {(k[0] ? {1'b0, w[9:8]} : a[6:4]),
            3'h0, w[7:0], w[7:0]});
        if (sc == 8)
          chk(mem.ram_mem[dp_in], k[0] ? m | 1 << j : m & ~(1 << j));
        if (sc == 9 || sc == 10 || sc == 13)
          chk(stat[7:5], 3'h0);
        if (sc == 13)
          chk(dpr, dp_in);
        if (sc == 11)
          chk(rom_addr[11:7], p[4:0] | 5'h01);
        if (sc == 12)
          chk(stat[2], k[1] & k[3]);
      end
    end_of_test(0);
  end
endmodule : test_cpu_instruction_execute
